// [design/alod_decoder.sv]
// Purpose: Decodes adjust, divide, sign-extend, logic and shift opcodes.
// Assumes: Bytes come one per cycle with byte_valid; byte_ready stalls.
// Notes:   Each decoded instruction holds busy for its clock count.
//
// How it works
// - Bytes d4 then 0a decode as ascii adjust after multiply, 19 clocks.
// - Group 3 with sub-opcode 6 is unsigned divide, 29/38/35/44 clocks.
// - Group 3 with sub-opcode 7 is signed divide with the same timing.
// - Bytes d5 then 0a decode as ascii adjust before divide, 15 clocks.
// - Byte 98 is byte_sign_extend, 2 clocks.
// - Byte 99 is word_sign_extend, 4 clocks.
// - Exclusive-or decodes in rm 3/10, immediate 4/10, accumulator 3/4.
// - Test ANDs for flags only, rm form 3/10 and immediate form 4/10.
// - Opcode d0/d1 shifts by one, shift_operation_select picks it, 2/15.
// - Accumulator forms take the first figure for 8 bits, second for 16.
`timescale 1ns/1ps
module alod_decoder #(
   parameter int CW = 6
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic [7:0]         byte_in,
   input  wire logic               byte_valid,
   output logic                    byte_ready,
   output alod_pkg::alod_op_t      op_out,
   output logic                    op_word,
   output logic                    op_mem,
   output logic                    op_result_discard,
   output logic [2:0]              shift_operation_select,
   output logic [CW-1:0]           op_clocks,
   output logic                    op_start,
   output logic                    op_done,
   output logic                    illegal
);
   import alod_pkg::*;

   // ==========================================================
   // State machine
   typedef enum logic [3:0] {
      ST_OP   = 4'b0001,
      ST_SEC  = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_WAIT = 4'b1000
   } alod_state_t;

   alod_state_t state_reg;
   alod_state_t state_next;
   logic [7:0]  first_reg;
   logic        busy;
   logic        tdone;

   wire take = byte_valid && byte_ready;
   wire w0   = first_reg[0];

   // ==========================================================
   // First byte classes
   wire b_grp3  = byte_in[7:1] == OPC_GRP3;
   wire b_grp1  = byte_in[7:1] == OPC_GRP1;
   wire b_testr = byte_in[7:1] == OPC_TEST_RM;
   wire b_shf   = byte_in[7:1] == OPC_SHIFT1;
   wire b_rm    = byte_in[7:2] == OPC_AND_RM || byte_in[7:2] == OPC_OR_RM ||
                  byte_in[7:2] == OPC_XOR_RM;
   wire b_adj   = byte_in == OPC_ADJ_MUL || byte_in == OPC_ADJ_DIV;
   wire b_acc   = byte_in[7:1] == OPC_AND_ACC || byte_in[7:1] == OPC_OR_ACC ||
                  byte_in[7:1] == OPC_XOR_ACC;
   wire b_sx    = byte_in == OPC_BYTE_SX || byte_in == OPC_WORD_SX;
   wire b_two   = b_grp3 || b_grp1 || b_testr || b_shf || b_rm || b_adj;

   // ==========================================================
   // Single byte decode
   wire alod_op_t one_op =
      byte_in == OPC_BYTE_SX         ? ALOD_OP_BSX :
      byte_in == OPC_WORD_SX         ? ALOD_OP_WSX :
      byte_in[7:1] == OPC_AND_ACC    ? ALOD_OP_AND :
      byte_in[7:1] == OPC_OR_ACC     ? ALOD_OP_OR  :
                                       ALOD_OP_XOR;
   wire [CW-1:0] one_clk =
      byte_in == OPC_BYTE_SX ? CW'(CLK_BYTE_SX) :
      byte_in == OPC_WORD_SX ? CW'(CLK_WORD_SX) :
      byte_in[0]             ? CW'(CLK_ACC_16) :
                               CW'(CLK_ACC_8);

   // ==========================================================
   // Second byte decode
   wire [2:0] sub = byte_in[5:3];
   wire       mem = byte_in[7:6] != MOD_REG;
   wire       f_grp3 = first_reg[7:1] == OPC_GRP3;
   wire       f_grp1 = first_reg[7:1] == OPC_GRP1;
   wire       f_shf  = first_reg[7:1] == OPC_SHIFT1;
   wire       f_test = first_reg[7:1] == OPC_TEST_RM;
   wire       f_adj  = first_reg == OPC_ADJ_MUL || first_reg == OPC_ADJ_DIV;
   wire [5:0] f_hi   = first_reg[7:2];

   wire [CW-1:0] div_clk = mem ? (w0 ? CW'(CLK_DIV_MW) : CW'(CLK_DIV_MB))
                               : (w0 ? CW'(CLK_DIV_RW) : CW'(CLK_DIV_RB));
   wire [CW-1:0] rm_clk  = mem ? CW'(CLK_RM_MEM) : CW'(CLK_RM_REG);
   wire [CW-1:0] imm_clk = mem ? CW'(CLK_IMM_MEM) : CW'(CLK_IMM_REG);
   wire [CW-1:0] shf_clk = mem ? CW'(CLK_SHF_MEM) : CW'(CLK_SHF_REG);

   wire sec_ok =
      (f_adj && byte_in == OPC_ADJ_BASE) ||
      (f_grp3 && (sub == SUB_UDIV || sub == SUB_SDIV || sub == SUB_TEST)) ||
      (f_grp1 && (sub == SUB_AND || sub == SUB_OR || sub == SUB_XOR)) ||
      f_shf || f_test || f_hi == OPC_AND_RM || f_hi == OPC_OR_RM ||
      f_hi == OPC_XOR_RM;

   wire alod_op_t two_op =
      f_adj && first_reg == OPC_ADJ_MUL ? ALOD_OP_AAM :
      f_adj                             ? ALOD_OP_AAD :
      f_grp3 && sub == SUB_UDIV         ? ALOD_OP_UDIV :
      f_grp3 && sub == SUB_SDIV         ? ALOD_OP_SDIV :
      f_grp3 || f_test                  ? ALOD_OP_TEST :
      f_shf                             ? ALOD_OP_SHIFT :
      f_grp1 && sub == SUB_AND          ? ALOD_OP_AND :
      f_grp1 && sub == SUB_OR           ? ALOD_OP_OR  :
      f_grp1                            ? ALOD_OP_XOR :
      f_hi == OPC_AND_RM                ? ALOD_OP_AND :
      f_hi == OPC_OR_RM                 ? ALOD_OP_OR  :
                                          ALOD_OP_XOR;

   wire [CW-1:0] two_clk =
      first_reg == OPC_ADJ_MUL        ? CW'(CLK_ADJ_MUL) :
      f_adj                           ? CW'(CLK_ADJ_DIV) :
      f_grp3 && sub != SUB_TEST       ? div_clk :
      f_grp3                          ? imm_clk :
      f_shf                           ? shf_clk :
      f_grp1 && sub == SUB_AND && mem ? CW'(CLK_AND_IMEM) :
      f_grp1                          ? imm_clk :
                                        rm_clk;

   // ==========================================================
   // Control
   wire start1 = state_reg == ST_OP && take && (b_acc || b_sx);
   wire start2 = state_reg == ST_SEC && take && sec_ok;
   wire bad1   = state_reg == ST_OP && take && !(b_acc || b_sx || b_two);
   wire bad2   = state_reg == ST_SEC && take && !sec_ok;
   wire tload  = start1 || start2;
   wire [CW-1:0] tcount = start1 ? one_clk : two_clk;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OP: begin
            if (take && (b_acc || b_sx)) state_next = ST_EXEC;
            else if (take && b_two) state_next = ST_SEC;
         end
         ST_SEC:  if (take) state_next = sec_ok ? ST_EXEC : ST_OP;
         ST_EXEC: state_next = ST_WAIT;
         ST_WAIT: if (!busy) state_next = ST_OP;
         default: state_next = ST_OP;
      endcase
   end

   // Ready is registered from the next state so that it leaves a flip-flop.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg  <= ST_OP;
         first_reg  <= '0;
         byte_ready <= 1'b1;
      end else begin
         state_reg  <= state_next;
         byte_ready <= state_next == ST_OP || state_next == ST_SEC;
         if (state_reg == ST_OP && take) first_reg <= byte_in;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_out                 <= ALOD_OP_NONE;
         op_word                <= 1'b0;
         op_mem                 <= 1'b0;
         op_result_discard      <= 1'b0;
         shift_operation_select <= '0;
         op_clocks              <= '0;
         op_start               <= 1'b0;
         illegal                <= 1'b0;
      end else begin
         op_start <= tload;
         illegal  <= bad1 || bad2;
         if (start1) begin
            op_out            <= one_op;
            op_word           <= byte_in[0];
            op_mem            <= 1'b0;
            op_result_discard <= 1'b0;
            op_clocks         <= one_clk;
         end else if (start2) begin
            op_out            <= two_op;
            op_word           <= w0;
            op_mem            <= mem;
            op_result_discard <= two_op == ALOD_OP_TEST;
            shift_operation_select <= sub;
            op_clocks         <= two_clk;
         end
      end
   end

   alod_cycle_timer #(.W(CW)) u_timer (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (tload),
      .count   (tcount),
      .busy    (busy),
      .done    (tdone)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) op_done <= 1'b0;
      else          op_done <= tdone;
   end

   // ==========================================================
   // Checks
   a_aam_clocks: assert property (@(posedge clk)
      disable iff (!reset_n)
      op_start && op_out == ALOD_OP_AAM |-> op_clocks == CW'(CLK_ADJ_MUL))
      else $error("ascii adjust after multiply clocks wrong");
   a_udiv_clocks: assert property (@(posedge clk)
      disable iff (!reset_n)
      op_start && op_out == ALOD_OP_UDIV |-> op_clocks ==
      (op_mem ? (op_word ? CW'(CLK_DIV_MW) : CW'(CLK_DIV_MB))
              : (op_word ? CW'(CLK_DIV_RW) : CW'(CLK_DIV_RB))))
      else $error("unsigned divide clocks wrong");
   a_sdiv_clocks: assert property (@(posedge clk)
      disable iff (!reset_n)
      op_start && op_out == ALOD_OP_SDIV |-> op_clocks ==
      (op_mem ? (op_word ? CW'(CLK_DIV_MW) : CW'(CLK_DIV_MB))
              : (op_word ? CW'(CLK_DIV_RW) : CW'(CLK_DIV_RB))))
      else $error("signed divide clocks wrong");
   a_aad_decode: assert property (@(posedge clk)
      disable iff (!reset_n)
      state_reg == ST_SEC && take && first_reg == OPC_ADJ_DIV &&
      byte_in == OPC_ADJ_BASE |=> op_start && op_out == ALOD_OP_AAD &&
      op_clocks == CW'(CLK_ADJ_DIV))
      else $error("ascii adjust before divide not decoded");
   a_bsx_decode: assert property (@(posedge clk)
      disable iff (!reset_n)
      state_reg == ST_OP && take && byte_in == OPC_BYTE_SX
      |=> op_start && op_out == ALOD_OP_BSX && op_clocks == CW'(CLK_BYTE_SX))
      else $error("byte sign extend not decoded");
   a_wsx_done: assert property (@(posedge clk)
      disable iff (!reset_n)
      state_reg == ST_OP && take && byte_in == OPC_WORD_SX
      |=> op_out == ALOD_OP_WSX ##(4) op_done)
      else $error("word sign extend timing wrong");
   a_xor_acc: assert property (@(posedge clk)
      disable iff (!reset_n)
      state_reg == ST_OP && take && byte_in[7:1] == OPC_XOR_ACC
      |=> op_out == ALOD_OP_XOR && !op_mem)
      else $error("xor accumulator form not decoded");
   a_test_discard: assert property (@(posedge clk)
      disable iff (!reset_n)
      op_start |-> op_result_discard == (op_out == ALOD_OP_TEST))
      else $error("test result not discarded");
   a_shift_clocks: assert property (@(posedge clk)
      disable iff (!reset_n)
      op_start && op_out == ALOD_OP_SHIFT
      |-> op_clocks == (op_mem ? CW'(CLK_SHF_MEM) : CW'(CLK_SHF_REG)))
      else $error("shift clocks wrong");
   a_acc_width: assert property (@(posedge clk)
      disable iff (!reset_n)
      state_reg == ST_OP && take && b_acc
      |=> op_clocks == (op_word ? CW'(CLK_ACC_16) : CW'(CLK_ACC_8)))
      else $error("accumulator form width timing wrong");
   a_and_imm: assert property (@(posedge clk)
      disable iff (!reset_n)
      state_reg == ST_SEC && take && f_grp1 && sub == SUB_AND && mem
      |=> op_out == ALOD_OP_AND && op_clocks == CW'(CLK_AND_IMEM))
      else $error("and immediate memory clocks wrong");
   a_or_imm: assert property (@(posedge clk)
      disable iff (!reset_n)
      state_reg == ST_SEC && take && f_grp1 && sub == SUB_OR && mem
      |=> op_out == ALOD_OP_OR && op_clocks == CW'(CLK_IMM_MEM))
      else $error("or immediate memory clocks wrong");

endmodule : alod_decoder

// [design/alod_pkg.sv]
// Purpose: Shared constants for the arithmetic and logic opcode decoder.
// Assumes: Opcode bytes arrive one per cycle from the prefetch queue.
// Notes:   Clock figures are core clocks of the executing datapath.
package alod_pkg;

   // ==========================================================
   // Opcode patterns
   localparam logic [7:0] OPC_ADJ_MUL   = 8'hd4;
   localparam logic [7:0] OPC_ADJ_DIV   = 8'hd5;
   localparam logic [7:0] OPC_ADJ_BASE  = 8'h0a;
   localparam logic [7:0] OPC_BYTE_SX   = 8'h98;
   localparam logic [7:0] OPC_WORD_SX   = 8'h99;
   localparam logic [6:0] OPC_GRP3      = 7'h7b;
   localparam logic [6:0] OPC_GRP1      = 7'h40;
   localparam logic [6:0] OPC_TEST_RM   = 7'h42;
   localparam logic [6:0] OPC_SHIFT1    = 7'h68;
   localparam logic [5:0] OPC_AND_RM    = 6'h08;
   localparam logic [5:0] OPC_OR_RM     = 6'h02;
   localparam logic [5:0] OPC_XOR_RM    = 6'h0c;
   localparam logic [6:0] OPC_AND_ACC   = 7'h12;
   localparam logic [6:0] OPC_OR_ACC    = 7'h06;
   localparam logic [6:0] OPC_XOR_ACC   = 7'h1a;

   // ==========================================================
   // ModRM sub-opcodes
   localparam logic [2:0] SUB_TEST = 3'h0;
   localparam logic [2:0] SUB_OR   = 3'h1;
   localparam logic [2:0] SUB_AND  = 3'h4;
   localparam logic [2:0] SUB_XOR  = 3'h6;
   localparam logic [2:0] SUB_UDIV = 3'h6;
   localparam logic [2:0] SUB_SDIV = 3'h7;
   localparam logic [1:0] MOD_REG  = 2'h3;

   // ==========================================================
   // Clock counts
   localparam logic [5:0] CLK_ADJ_MUL  = 6'h13;
   localparam logic [5:0] CLK_ADJ_DIV  = 6'h0f;
   localparam logic [5:0] CLK_DIV_RB   = 6'h1d;
   localparam logic [5:0] CLK_DIV_RW   = 6'h26;
   localparam logic [5:0] CLK_DIV_MB   = 6'h23;
   localparam logic [5:0] CLK_DIV_MW   = 6'h2c;
   localparam logic [5:0] CLK_BYTE_SX  = 6'h02;
   localparam logic [5:0] CLK_WORD_SX  = 6'h04;
   localparam logic [5:0] CLK_RM_REG   = 6'h03;
   localparam logic [5:0] CLK_RM_MEM   = 6'h0a;
   localparam logic [5:0] CLK_IMM_REG  = 6'h04;
   localparam logic [5:0] CLK_IMM_MEM  = 6'h0a;
   localparam logic [5:0] CLK_AND_IMEM = 6'h10;
   localparam logic [5:0] CLK_ACC_8    = 6'h03;
   localparam logic [5:0] CLK_ACC_16   = 6'h04;
   localparam logic [5:0] CLK_SHF_REG  = 6'h02;
   localparam logic [5:0] CLK_SHF_MEM  = 6'h0f;

   // ==========================================================
   // Operation codes handed to the datapath
   typedef enum logic [3:0] {
      ALOD_OP_NONE   = 4'h0,
      ALOD_OP_AAM    = 4'h1,
      ALOD_OP_AAD    = 4'h2,
      ALOD_OP_UDIV   = 4'h3,
      ALOD_OP_SDIV   = 4'h4,
      ALOD_OP_BSX    = 4'h5,
      ALOD_OP_WSX    = 4'h6,
      ALOD_OP_AND    = 4'h7,
      ALOD_OP_OR     = 4'h8,
      ALOD_OP_XOR    = 4'h9,
      ALOD_OP_TEST   = 4'ha,
      ALOD_OP_SHIFT  = 4'hb
   } alod_op_t;

endpackage : alod_pkg

// [design/alod_cycle_timer.sv]
// Purpose: Counts down the execution clocks of one instruction.
// Assumes: A load arrives only while the timer is idle.
// Notes:   Done pulses in the last clock of the instruction.
`timescale 1ns/1ps
module alod_cycle_timer #(
   parameter int W = 6
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_reg;
   wire          last = busy && (cnt_reg == W'(1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt_reg <= count;
            busy    <= 1'b1;
         end else if (busy) begin
            cnt_reg <= cnt_reg - W'(1);
            if (cnt_reg == W'(2)) done <= 1'b1;
            if (last) busy <= 1'b0;
         end
      end
   end
endmodule : alod_cycle_timer

// [verif/alod_decoder_bench.sv]
// Purpose: Self-checking bench for the arithmetic and logic opcode decoder.
// Assumes: Inputs change at the falling edge; outputs sampled there too.
// Notes:   Expected values come from the opcode and clock tables.
`timescale 1ns/1ps
module alod_decoder_bench;
   import alod_pkg::*;

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

   // ==========================================================
   // Clock, reset and design instance
   logic               clk;
   logic               reset_n;
   logic [7:0]         byte_in;
   logic               byte_valid;
   logic               byte_ready;
   alod_op_t           op_out;
   logic               op_word;
   logic               op_mem;
   logic               op_result_discard;
   logic [2:0]         shift_operation_select;
   logic [5:0]         op_clocks;
   logic               op_start;
   logic               op_done;
   logic               illegal;
   int                 n_mismatch = 0;
   int                 n_checks = 0;
   int                 cycles = 0;

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   alod_decoder #(.CW(6)) alod_decoder_i (
      .clk                    (clk),
      .reset_n                (reset_n),
      .byte_in                (byte_in),
      .byte_valid             (byte_valid),
      .byte_ready             (byte_ready),
      .op_out                 (op_out),
      .op_word                (op_word),
      .op_mem                 (op_mem),
      .op_result_discard      (op_result_discard),
      .shift_operation_select (shift_operation_select),
      .op_clocks              (op_clocks),
      .op_start               (op_start),
      .op_done                (op_done),
      .illegal                (illegal)
   );

   // ==========================================================
   // Shared tasks
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   function automatic logic [7:0] mrm(input logic m, input logic [2:0] r);
      return {(m ? 2'b00 : 2'b11), r, 3'b000};
   endfunction : mrm

   task automatic send_byte(input logic [7:0] b);
      int k;
      k = 0;
      while (byte_ready !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      byte_in = b;
      byte_valid = 1'b1;
      @(negedge clk);
   endtask : send_byte

   task automatic run_op(input logic [7:0] b0, input logic [7:0] b1,
                         input int nb, input alod_op_t eop,
                         input logic [5:0] eclk, input logic chk_wm,
                         input logic ew, input logic em,
                         input logic edisc);
      int k;
      send_byte(b0);
      if (nb == 2)
         send_byte(b1);
      byte_valid = 1'b0;
      byte_in = ~byte_in;
      k = 0;
      while (op_start !== 1'b1 && k < 4) begin
         @(negedge clk);
         k++;
      end
      // The start pulse already stands at the first falling edge.
      `CHK(k, 0)
      `CHK(op_out, eop)
      `CHK(op_clocks, eclk)
      `CHK(op_result_discard, edisc)
      `CHK(byte_ready, 1'b0)
      if (chk_wm) begin
         `CHK(op_word, ew)
         `CHK(op_mem, em)
      end
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (op_done !== 1'b1 && k < 60);
      `CHK(k, int'(eclk))
      k = 0;
      while (byte_ready !== 1'b1 && k < 4) begin
         @(negedge clk);
         k++;
      end
      `CHK(byte_ready, 1'b1)
   endtask : run_op

   task automatic run_bad(input logic [7:0] b0, input logic [7:0] b1,
                          input int nb);
      logic seen_ill;
      logic seen_start;
      seen_ill = 1'b0;
      seen_start = 1'b0;
      send_byte(b0);
      if (nb == 2)
         send_byte(b1);
      byte_valid = 1'b0;
      repeat (4) begin
         if (illegal === 1'b1) seen_ill = 1'b1;
         if (op_start === 1'b1) seen_start = 1'b1;
         @(negedge clk);
      end
      `CHK(seen_ill, 1'b1)
      `CHK(seen_start, 1'b0)
      `CHK(byte_ready, 1'b1)
   endtask : run_bad

   // ==========================================================
   // Scenarios
   task automatic test_adjust();
      run_op(8'hd4, 8'h0a, 2, ALOD_OP_AAM, 6'd19, 0, 0, 0, 0);
      run_op(8'hd5, 8'h0a, 2, ALOD_OP_AAD, 6'd15, 0, 0, 0, 0);
      run_bad(8'hd4, 8'h0b, 2);
      run_bad(8'hd5, 8'h00, 2);
      $display("test adjust done");
   endtask : test_adjust

   task automatic test_divide();
      logic [5:0] t [4] = '{6'd29, 6'd38, 6'd35, 6'd44};
      for (int s = 6; s <= 7; s++)
         for (int m = 0; m < 2; m++)
            for (int w = 0; w < 2; w++)
               run_op({7'h7b, w[0]}, mrm(m[0], s[2:0]), 2,
                      (s == 6) ? ALOD_OP_UDIV : ALOD_OP_SDIV,
                      t[m * 2 + w], 1, w[0], m[0], 0);
      $display("test divide done");
   endtask : test_divide

   task automatic test_sign_ext();
      run_op(8'h98, 8'h00, 1, ALOD_OP_BSX, 6'd2, 0, 0, 0, 0);
      run_op(8'h99, 8'h00, 1, ALOD_OP_WSX, 6'd4, 0, 0, 0, 0);
      $display("test sign extend done");
   endtask : test_sign_ext

   task automatic test_logic();
      alod_op_t   op [3] = '{ALOD_OP_AND, ALOD_OP_OR, ALOD_OP_XOR};
      logic [5:0] rb [3] = '{6'h08, 6'h02, 6'h0c};
      logic [6:0] ab [3] = '{7'h12, 7'h06, 7'h1a};
      logic [2:0] sb [3] = '{3'h4, 3'h1, 3'h6};
      logic [5:0] im [3] = '{6'd16, 6'd10, 6'd10};
      for (int i = 0; i < 3; i++)
         for (int w = 0; w < 2; w++) begin
            for (int m = 0; m < 2; m++) begin
               run_op({rb[i], m[0], w[0]}, mrm(m[0], 3'h5), 2, op[i],
                      m ? 6'd10 : 6'd3, 1, w[0], m[0], 0);
               run_op({7'h40, w[0]}, mrm(m[0], sb[i]), 2, op[i],
                      m ? im[i] : 6'd4, 1, w[0], m[0], 0);
            end
            run_op({ab[i], w[0]}, 8'h00, 1, op[i],
                   w ? 6'd4 : 6'd3, 1, w[0], 0, 0);
         end
      $display("test logic done");
   endtask : test_logic

   task automatic test_test();
      for (int m = 0; m < 2; m++)
         for (int w = 0; w < 2; w++) begin
            run_op({7'h42, w[0]}, mrm(m[0], 3'h2), 2, ALOD_OP_TEST,
                   m ? 6'd10 : 6'd3, 1, w[0], m[0], 1);
            run_op({7'h7b, w[0]}, mrm(m[0], 3'h0), 2, ALOD_OP_TEST,
                   m ? 6'd10 : 6'd4, 1, w[0], m[0], 1);
         end
      $display("test test done");
   endtask : test_test

   task automatic test_shift();
      logic m;
      for (int s = 0; s < 8; s++) begin
         m = s[1];
         run_op({7'h68, s[0]}, mrm(m, s[2:0]), 2, ALOD_OP_SHIFT,
                m ? 6'd15 : 6'd2, 1, s[0], m, 0);
         `CHK(shift_operation_select, s[2:0])
      end
      $display("test shift done");
   endtask : test_shift

   task automatic test_illegal();
      run_bad(8'h80, mrm(1'b0, 3'h0), 2);
      run_bad(8'hf7, mrm(1'b1, 3'h2), 2);
      run_bad(8'h00, 8'h00, 1);
      run_op(8'h98, 8'h00, 1, ALOD_OP_BSX, 6'd2, 0, 0, 0, 0);
      $display("test illegal done");
   endtask : test_illegal

   // ==========================================================
   // Main sequence and hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial begin
      reset_n = 1'b0;
      byte_in = 8'h00;
      byte_valid = 1'b0;
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      `CHK(op_out, ALOD_OP_NONE)
      `CHK(byte_ready, 1'b1)
      test_adjust();
      test_divide();
      test_sign_ext();
      test_logic();
      test_test();
      test_shift();
      test_illegal();
      print_verdict();
   end

endmodule : alod_decoder_bench
